// ---- hdl/fdc_interval_timer.sv ----
// down counter paced by a one-cycle tick
`timescale 1ns/10ps
`default_nettype none
module fdc_interval_timer #(
  parameter int WIDTH = 8
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic tick,
  input wire logic load,
  input wire logic [WIDTH-1:0] value,
  output logic done
);
  logic [WIDTH-1:0] cnt_r, cnt_nxt;
  logic run_r, run_nxt;
  logic done_nxt;

  // load wins over counting; zero value ends on first tick
  always_comb begin
    cnt_nxt = cnt_r;
    run_nxt = run_r;
    done_nxt = 1'b0;
    if (load) begin
      cnt_nxt = value;
      run_nxt = 1'b1;
    end else if (run_r && tick) begin
      if (cnt_r <= {{(WIDTH-1){1'b0}}, 1'b1}) begin
        run_nxt = 1'b0;
        done_nxt = 1'b1;
      end else begin
        cnt_nxt = cnt_r - {{(WIDTH-1){1'b0}}, 1'b1};
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cnt_r <= '0;
      run_r <= 1'b0;
      done <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      run_r <= run_nxt;
      done <= done_nxt;
    end
  end
endmodule
`default_nettype wire

// ---- hdl/fdc_param_pkg.sv ----
// constants shared by the floppy command parameter decoder
package fdc_param_pkg;
  // apb register byte offsets
  localparam logic [7:0] OFF_CMD = 8'h00;
  localparam logic [7:0] OFF_PARAM = 8'h04;
  localparam logic [7:0] OFF_CONFIG = 8'h08;
  localparam logic [7:0] OFF_PERP = 8'h0C;
  localparam logic [7:0] OFF_SPECIFY = 8'h10;
  localparam logic [7:0] OFF_RESET = 8'h14;
  localparam logic [7:0] OFF_STATUS = 8'h18;
  localparam logic [7:0] OFF_DATA = 8'h1C;
  // command byte field positions
  localparam int CMD_MT_BIT = 7;
  localparam int CMD_DD_BIT = 6;
  localparam int CMD_HEAD_BIT = 2;
  // parameter register fields
  localparam int PAR_N_LSB = 0;
  localparam int PAR_DTL_LSB = 8;
  localparam int PAR_EOT_LSB = 16;
  localparam int PAR_ND_BIT = 24;
  localparam int PAR_RD_BIT = 25;
  // config register fields
  localparam int CFG_THR_LSB = 0;
  localparam int CFG_QDIS_BIT = 4;
  localparam int CFG_SEEK_BIT = 5;
  localparam int CFG_LOCK_BIT = 6;
  localparam int CFG_TRK_LSB = 8;
  // perpendicular register fields
  localparam int PERP_OW_BIT = 4;
  // reset values
  localparam logic [3:0] RST_THR = 4'h0;
  localparam logic RST_QDIS_N = 1'b1;
  localparam logic [7:0] RST_TRK = 8'h00;
  localparam logic RST_SEEK = 1'b0;
  localparam logic [7:0] RST_HLT = 8'h01;
  localparam logic [7:0] RST_HUT = 8'h01;
  // interval tick: 1 us at 100 MHz
  localparam int TICK_NS = 1000;
  localparam int CLK_NS = 10;
  localparam int TICK_CYC = TICK_NS / CLK_NS;
  localparam int SECTOR_BASE = 128;
  localparam logic [2:0] N_MAX = 3'h7;
  typedef enum logic [2:0] {ST_IDLE, ST_SEEK, ST_SETTLE, ST_XFER, ST_HOLD} seq_state_t;
endpackage

// ---- hdl/floppy_cmd_param_decode.sv ----
// floppy command parameter decoder and transfer sequencer
`timescale 1ns/10ps
`default_nettype none
//////////////////////////////////////////////////////////////////////////////
// Contract
// RQ1 - wait head settle interval after head load before media access
// RQ2 - keep head loaded for release interval after execution, then unload
// RQ3 - lock bit keeps queue and precomp settings across software reset
// RQ4 - density bit one selects double density, zero single density
// RQ5 - both-sides flag spans head 0 first sector to head 1 last
// RQ6 - after last head 0 sector continue on head 1 automatically
// RQ7 - size code zero means 128 bytes, count from short length
// RQ8 - nonzero code gives 128 shl code, codes up to seven
// RQ9 - software avoids impossible size combinations; no guard here
// RQ10 - no-dma flag set raises host interrupt per data byte
// RQ11 - no-dma clear uses request/acknowledge handshake with dma controller
// RQ12 - perpendicular drive bits change only with write-enable bit set
// RQ13 - short length counts bytes passed; remainder read but dropped
// RQ14 - queue disable high bypasses fifo, bytes moved singly
// RQ15 - auto seek enabled seeks to cylinder before read or write
module floppy_cmd_param_decode #(
  parameter int TICK_CYCLES = fdc_param_pkg::TICK_CYC
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic dack_n,
  input wire logic byte_strobe,
  input wire logic seek_done,
  output logic drq,
  output logic byte_irq,
  output logic head_load,
  output logic seek_req,
  output logic [7:0] seek_cyl,
  output logic head_sel,
  output logic double_density_sel,
  output logic fifo_bypass,
  output logic byte_pass
);
  //////////////////////////////////////////////////////////////////////////
  // register state
  logic [7:0] cmd_r, cmd_nxt;
  logic [7:0] cyl_r, cyl_nxt;
  logic [2:0] size_code_r, size_code_nxt;
  logic [7:0] short_sector_length_r, short_sector_length_nxt;
  logic [7:0] eot_r, eot_nxt;
  logic no_dma_flag_r, no_dma_flag_nxt;
  logic is_read_r, is_read_nxt;
  logic [3:0] queue_threshold_r, queue_threshold_nxt;
  logic queue_disable_n_r, queue_disable_n_nxt;
  logic auto_seek_enable_r, auto_seek_enable_nxt;
  logic lock_r, lock_nxt;
  logic [7:0] precomp_first_track_r, precomp_first_track_nxt;
  logic [3:0] perp_r, perp_nxt;
  logic [7:0] head_settle_interval_r, head_settle_interval_nxt;
  logic [7:0] head_release_interval_r, head_release_interval_nxt;
  logic [31:0] prdata_nxt;
  logic pready_nxt, pslverr_nxt;
  logic start_pulse;

  logic wr_en, rd_en;
  assign wr_en = psel && penable && pwrite && !pready;
  assign rd_en = psel && penable && !pwrite && !pready;

  // sector length in bytes from size code; shared by count and data register read
  function automatic logic [14:0] sector_bytes(input logic [2:0] code);
    sector_bytes = 15'(fdc_param_pkg::SECTOR_BASE) << code; // RQ8
  endfunction

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // sequencer state
  fdc_param_pkg::seq_state_t state_r, state_nxt;
  logic [7:0] sector_r, sector_nxt;
  logic head_r, head_nxt;
  logic [14:0] byte_cnt_r, byte_cnt_nxt;
  logic drq_nxt, byte_irq_nxt, head_load_nxt, seek_req_nxt, byte_pass_nxt;
  logic settle_load, release_load, settle_done, release_done;
  logic [$clog2(TICK_CYCLES+1)-1:0] tick_cnt_r, tick_cnt_nxt;
  logic tick_r, tick_nxt;
  logic busy;
  assign busy = (state_r != fdc_param_pkg::ST_IDLE) && (state_r != fdc_param_pkg::ST_HOLD);

  //////////////////////////////////////////////////////////////////////////
  // apb register writes, reads and software reset
  always_comb begin
    cmd_nxt = cmd_r;
    cyl_nxt = cyl_r;
    size_code_nxt = size_code_r;
    short_sector_length_nxt = short_sector_length_r;
    eot_nxt = eot_r;
    no_dma_flag_nxt = no_dma_flag_r;
    is_read_nxt = is_read_r;
    queue_threshold_nxt = queue_threshold_r;
    queue_disable_n_nxt = queue_disable_n_r;
    auto_seek_enable_nxt = auto_seek_enable_r;
    lock_nxt = lock_r;
    precomp_first_track_nxt = precomp_first_track_r;
    perp_nxt = perp_r;
    head_settle_interval_nxt = head_settle_interval_r;
    head_release_interval_nxt = head_release_interval_r;
    start_pulse = 1'b0;
    prdata_nxt = 32'h0000_0000;
    pslverr_nxt = 1'b0;
    pready_nxt = psel && penable && !pready;
    if (wr_en) begin
      if (hit(paddr, fdc_param_pkg::OFF_CMD)) begin
        cmd_nxt = busy ? cmd_r : pwdata[7:0]; // refused command must not disturb the running one
        cyl_nxt = busy ? cyl_r : pwdata[15:8];
        start_pulse = !busy;
        pslverr_nxt = busy; // commands refused mid-transfer
      end else if (hit(paddr, fdc_param_pkg::OFF_PARAM)) begin
        size_code_nxt = pwdata[fdc_param_pkg::PAR_N_LSB +: 3];
        short_sector_length_nxt = pwdata[fdc_param_pkg::PAR_DTL_LSB +: 8];
        eot_nxt = pwdata[fdc_param_pkg::PAR_EOT_LSB +: 8];
        no_dma_flag_nxt = pwdata[fdc_param_pkg::PAR_ND_BIT];
        is_read_nxt = pwdata[fdc_param_pkg::PAR_RD_BIT];
      end else if (hit(paddr, fdc_param_pkg::OFF_CONFIG)) begin
        queue_threshold_nxt = pwdata[fdc_param_pkg::CFG_THR_LSB +: 4];
        queue_disable_n_nxt = pwdata[fdc_param_pkg::CFG_QDIS_BIT];
        auto_seek_enable_nxt = pwdata[fdc_param_pkg::CFG_SEEK_BIT];
        lock_nxt = pwdata[fdc_param_pkg::CFG_LOCK_BIT];
        precomp_first_track_nxt = pwdata[fdc_param_pkg::CFG_TRK_LSB +: 8];
      end else if (hit(paddr, fdc_param_pkg::OFF_PERP)) begin
        if (pwdata[fdc_param_pkg::PERP_OW_BIT])
          perp_nxt = pwdata[3:0]; // RQ12
      end else if (hit(paddr, fdc_param_pkg::OFF_SPECIFY)) begin
        head_settle_interval_nxt = pwdata[7:0];
        head_release_interval_nxt = pwdata[15:8];
      end else if (hit(paddr, fdc_param_pkg::OFF_RESET)) begin
        // software reset; locked settings survive it
        if (pwdata[0] && !lock_r) begin
          queue_threshold_nxt = fdc_param_pkg::RST_THR; // RQ3
          queue_disable_n_nxt = fdc_param_pkg::RST_QDIS_N; // RQ3
          precomp_first_track_nxt = fdc_param_pkg::RST_TRK; // RQ3
        end
      end else begin
        pslverr_nxt = 1'b1;
      end
    end
    if (rd_en) begin
      if (hit(paddr, fdc_param_pkg::OFF_CMD)) begin
        prdata_nxt = {16'h0000, cyl_r, cmd_r};
      end else if (hit(paddr, fdc_param_pkg::OFF_PARAM)) begin
        prdata_nxt = {6'h00, is_read_r, no_dma_flag_r, eot_r, short_sector_length_r, 5'h00, size_code_r};
      end else if (hit(paddr, fdc_param_pkg::OFF_CONFIG)) begin
        prdata_nxt = {16'h0000, precomp_first_track_r, 1'b0, lock_r, auto_seek_enable_r,
                      queue_disable_n_r, queue_threshold_r};
      end else if (hit(paddr, fdc_param_pkg::OFF_PERP)) begin
        prdata_nxt = {28'h0000000, perp_r};
      end else if (hit(paddr, fdc_param_pkg::OFF_SPECIFY)) begin
        prdata_nxt = {16'h0000, head_release_interval_r, head_settle_interval_r};
      end else if (hit(paddr, fdc_param_pkg::OFF_RESET)) begin
        prdata_nxt = 32'h0000_0000;
      end else if (hit(paddr, fdc_param_pkg::OFF_STATUS)) begin
        prdata_nxt = {1'b0, byte_cnt_r, sector_r, 4'h0, head_r, 3'(state_r)};
      end else if (hit(paddr, fdc_param_pkg::OFF_DATA)) begin
        prdata_nxt = {17'h00000, sector_bytes(size_code_r)};
      end else begin
        pslverr_nxt = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cmd_r <= 8'h00;
      cyl_r <= 8'h00;
      size_code_r <= 3'h0;
      short_sector_length_r <= 8'h00;
      eot_r <= 8'h00;
      no_dma_flag_r <= 1'b0;
      is_read_r <= 1'b0;
      queue_threshold_r <= fdc_param_pkg::RST_THR;
      queue_disable_n_r <= fdc_param_pkg::RST_QDIS_N;
      auto_seek_enable_r <= fdc_param_pkg::RST_SEEK;
      lock_r <= 1'b0;
      precomp_first_track_r <= fdc_param_pkg::RST_TRK;
      perp_r <= 4'h0;
      head_settle_interval_r <= fdc_param_pkg::RST_HLT;
      head_release_interval_r <= fdc_param_pkg::RST_HUT;
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      cmd_r <= cmd_nxt;
      cyl_r <= cyl_nxt;
      size_code_r <= size_code_nxt;
      short_sector_length_r <= short_sector_length_nxt;
      eot_r <= eot_nxt;
      no_dma_flag_r <= no_dma_flag_nxt;
      is_read_r <= is_read_nxt;
      queue_threshold_r <= queue_threshold_nxt;
      queue_disable_n_r <= queue_disable_n_nxt;
      auto_seek_enable_r <= auto_seek_enable_nxt;
      lock_r <= lock_nxt;
      precomp_first_track_r <= precomp_first_track_nxt;
      perp_r <= perp_nxt;
      head_settle_interval_r <= head_settle_interval_nxt;
      head_release_interval_r <= head_release_interval_nxt;
      prdata <= prdata_nxt;
      pready <= pready_nxt;
      pslverr <= pslverr_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // interval tick divider
  always_comb begin
    tick_nxt = 1'b0;
    tick_cnt_nxt = tick_cnt_r + 1'b1;
    if (tick_cnt_r == ($bits(tick_cnt_r))'(TICK_CYCLES - 1)) begin
      tick_cnt_nxt = '0;
      tick_nxt = 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      tick_cnt_r <= '0;
      tick_r <= 1'b0;
    end else begin
      tick_cnt_r <= tick_cnt_nxt;
      tick_r <= tick_nxt;
    end
  end

  fdc_interval_timer #(.WIDTH(8)) settle_timer (
    .clk_sys(clk_sys),
    .rst(rst),
    .tick(tick_r),
    .load(settle_load),
    .value(head_settle_interval_r),
    .done(settle_done)
  );

  fdc_interval_timer #(.WIDTH(8)) release_timer (
    .clk_sys(clk_sys),
    .rst(rst),
    .tick(tick_r),
    .load(release_load),
    .value(head_release_interval_r),
    .done(release_done)
  );

  //////////////////////////////////////////////////////////////////////////
  // transfer sequencer; one byte per strobe or acknowledge
  logic byte_go, last_byte;
  logic [14:0] pass_len;
  // short length only applies to code zero; physical bytes still counted
  assign pass_len = (size_code_r == 3'h0) ? {7'h00, short_sector_length_r} : sector_bytes(size_code_r); // RQ7
  assign last_byte = (byte_cnt_r == sector_bytes(size_code_r) - 15'h0001);
  // dma mode paces on acknowledge, otherwise on host byte strobe
  assign byte_go = no_dma_flag_r ? byte_strobe : (drq && !dack_n); // RQ11

  always_comb begin
    state_nxt = state_r;
    sector_nxt = sector_r;
    head_nxt = head_r;
    byte_cnt_nxt = byte_cnt_r;
    drq_nxt = 1'b0;
    byte_irq_nxt = 1'b0;
    head_load_nxt = head_load;
    seek_req_nxt = 1'b0;
    byte_pass_nxt = 1'b0;
    settle_load = 1'b0;
    release_load = 1'b0;
    case (state_r)
      fdc_param_pkg::ST_IDLE, fdc_param_pkg::ST_HOLD: begin
        if (state_r == fdc_param_pkg::ST_HOLD && release_done) begin
          head_load_nxt = 1'b0; // RQ2
          state_nxt = fdc_param_pkg::ST_IDLE;
        end
        if (start_pulse) begin
          sector_nxt = 8'h01;
          head_nxt = cmd_nxt[fdc_param_pkg::CMD_HEAD_BIT];
          byte_cnt_nxt = 15'h0000;
          if (auto_seek_enable_r) begin
            seek_req_nxt = 1'b1; // RQ15
            state_nxt = fdc_param_pkg::ST_SEEK;
          end else begin
            head_load_nxt = 1'b1;
            settle_load = 1'b1;
            state_nxt = fdc_param_pkg::ST_SETTLE;
          end
        end
      end
      fdc_param_pkg::ST_SEEK: begin
        seek_req_nxt = !seek_done;
        if (seek_done) begin
          head_load_nxt = 1'b1;
          settle_load = 1'b1; // RQ15
          state_nxt = fdc_param_pkg::ST_SETTLE;
        end
      end
      fdc_param_pkg::ST_SETTLE: begin
        if (settle_done)
          state_nxt = fdc_param_pkg::ST_XFER; // RQ1
      end
      fdc_param_pkg::ST_XFER: begin
        // request held until a byte moves; interrupt re-raised per byte
        drq_nxt = !no_dma_flag_r && !byte_go; // RQ11
        byte_irq_nxt = no_dma_flag_r && !byte_go; // RQ10
        if (byte_go) begin
          byte_pass_nxt = byte_cnt_r < pass_len; // RQ13
          byte_cnt_nxt = byte_cnt_r + 15'h0001;
          if (last_byte) begin
            byte_cnt_nxt = 15'h0000;
            if (sector_r != eot_r) begin
              sector_nxt = sector_r + 8'h01;
            end else if (cmd_r[fdc_param_pkg::CMD_MT_BIT] && !head_r) begin
              sector_nxt = 8'h01; // RQ6
              head_nxt = 1'b1; // RQ5
            end else begin
              release_load = 1'b1; // RQ2
              drq_nxt = 1'b0;
              byte_irq_nxt = 1'b0;
              state_nxt = fdc_param_pkg::ST_HOLD;
            end
          end
        end
      end
      default: state_nxt = fdc_param_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state_r <= fdc_param_pkg::ST_IDLE;
      sector_r <= 8'h00;
      head_r <= 1'b0;
      byte_cnt_r <= 15'h0000;
      drq <= 1'b0;
      byte_irq <= 1'b0;
      head_load <= 1'b0;
      seek_req <= 1'b0;
      byte_pass <= 1'b0;
      seek_cyl <= 8'h00;
      head_sel <= 1'b0;
      double_density_sel <= 1'b0;
      fifo_bypass <= 1'b1;
    end else begin
      state_r <= state_nxt;
      sector_r <= sector_nxt;
      head_r <= head_nxt;
      byte_cnt_r <= byte_cnt_nxt;
      drq <= drq_nxt;
      byte_irq <= byte_irq_nxt;
      head_load <= head_load_nxt;
      seek_req <= seek_req_nxt;
      byte_pass <= byte_pass_nxt;
      seek_cyl <= cyl_r;
      head_sel <= head_nxt;
      double_density_sel <= cmd_r[fdc_param_pkg::CMD_DD_BIT]; // RQ4
      fifo_bypass <= queue_disable_n_r; // RQ14
    end
  end
endmodule
`default_nettype wire

// ---- testbench/fdc_host_dma_model.sv ----
// host processor and dma controller answering the decoder
`timescale 1ns/10ps
`default_nettype none
module fdc_host_dma_model (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic drq,
  input wire logic byte_irq,
  input wire logic seek_req,
  input wire logic [3:0] slow,
  output logic dack_n,
  output logic byte_strobe,
  output logic seek_done
);
  logic [3:0] cnt;
  // one answer per request, then a quiet cycle so a lingering request is not answered twice
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      dack_n <= 1'b1;
      byte_strobe <= 1'b0;
      seek_done <= 1'b0;
      cnt <= 4'h0;
    end else begin
      dack_n <= 1'b1;
      byte_strobe <= 1'b0;
      seek_done <= 1'b0;
      if (!dack_n || byte_strobe || seek_done) cnt <= 4'h0;
      else if ((drq || byte_irq || seek_req) && cnt < slow) cnt <= cnt + 4'h1;
      else if (drq) dack_n <= 1'b0;
      else if (byte_irq) byte_strobe <= 1'b1;
      else if (seek_req) seek_done <= 1'b1;
    end
  end
endmodule
`default_nettype wire

// ---- testbench/floppy_cmd_param_decode_bench.sv ----
// self-checking bench for the command parameter decoder
`timescale 1ns/10ps
`default_nettype none
module floppy_cmd_param_decode_bench;
  localparam int T = 2;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] slow = 4'h0;
  logic [31:0] prdata, r;
  logic [7:0] seek_cyl;
  logic pready, pslverr, dack_n, byte_strobe, seek_done, drq, byte_irq, head_load, seek_req;
  logic head_sel, double_density_sel, fifo_bypass, byte_pass, e;
  logic hl_q = 1'b0;
  int num_errors = 0;
  int num_checks = 0;
  int cyc = 0;
  int cnt [6];
  int up_t, last_t, settle, hold, xs;
  always #5 clk_sys = ~clk_sys;
  floppy_cmd_param_decode #(.TICK_CYCLES(T)) dut (.clk_sys(clk_sys), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .dack_n(dack_n), .byte_strobe(byte_strobe),
    .seek_done(seek_done), .drq(drq), .byte_irq(byte_irq), .head_load(head_load),
    .seek_req(seek_req), .seek_cyl(seek_cyl), .head_sel(head_sel),
    .double_density_sel(double_density_sel), .fifo_bypass(fifo_bypass), .byte_pass(byte_pass));
  fdc_host_dma_model host (.clk_sys(clk_sys), .rst(rst), .drq(drq), .byte_irq(byte_irq),
    .seek_req(seek_req), .slow(slow), .dack_n(dack_n), .byte_strobe(byte_strobe), .seek_done(seek_done));
  // counts moves per head, passes, seeks and the settle and hold spans
  always @(posedge clk_sys) begin
    cyc++;
    if (drq && !dack_n || byte_strobe) last_t = cyc;
    if (drq && !dack_n || byte_strobe) cnt[head_sel ? 1 : 0]++;
    if (byte_pass) cnt[2]++;
    if (drq && !dack_n) cnt[3]++;
    if (byte_strobe) cnt[4]++;
    if (seek_req && seek_done) cnt[5]++;
    if (!hl_q && head_load) up_t = cyc;
    if (hl_q && !head_load) hold = cyc - last_t;
    if ((drq || byte_irq) && xs == 0) settle = cyc - up_t;
    if (drq || byte_irq) xs = 1;
    hl_q = head_load;
  end
  task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task finish_test;
    if (num_errors == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // one apb transfer, held until pready, then an idle cycle
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) num_errors++;
    if (n >= 20) finish_test;
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask
  //////////////////////////////////////////////////////////////////////////////
  task t_regs;
    check("bypass", fifo_bypass, 1);
    apb(0, fdc_param_pkg::OFF_CONFIG, 0);
    check("config", r, 32'h10);
    apb(0, fdc_param_pkg::OFF_SPECIFY, 0);
    check("specify", r, 32'h101);
    apb(0, 8'h20, 0);
    check("unmapped", e, 1);
    apb(1, fdc_param_pkg::OFF_PERP, 32'h1A);
    apb(1, fdc_param_pkg::OFF_PERP, 32'h05);
    apb(0, fdc_param_pkg::OFF_PERP, 0);
    check("perp", r, 32'hA);
  endtask
  task t_size;
    for (int c = 0; c < 8; c++) begin
      apb(1, fdc_param_pkg::OFF_PARAM, c);
      apb(0, fdc_param_pkg::OFF_DATA, 0);
      check("size", r, 32'h80 << c);
    end
  endtask
  task t_lock;
    apb(1, fdc_param_pkg::OFF_CONFIG, 32'h3305);
    check("bypass off", fifo_bypass, 0);
    apb(1, fdc_param_pkg::OFF_RESET, 1);
    apb(0, fdc_param_pkg::OFF_CONFIG, 0);
    check("unlocked", r, 32'h10);
    apb(1, fdc_param_pkg::OFF_CONFIG, 32'h3345);
    apb(1, fdc_param_pkg::OFF_RESET, 1);
    apb(0, fdc_param_pkg::OFF_CONFIG, 0);
    check("locked", r, 32'h3345);
  endtask
  // full command; size and length pairs stay within what a drive can hold
  task t_run(input logic mt, dd, nd, sk, input logic [2:0] c, input logic [7:0] short_sector_length, lst, input logic [3:0] sl);
    int bpb, phys, hd, n;
    phys = 128 << c;
    bpb = (c == 0) ? short_sector_length : phys;
    hd = mt ? 2 : 1;
    n = 0;
    slow <= sl;
    apb(1, fdc_param_pkg::OFF_CONFIG, {26'h0, sk, 5'h10});
    apb(1, fdc_param_pkg::OFF_SPECIFY, 32'h0303);
    apb(1, fdc_param_pkg::OFF_PARAM, {6'h0, 1'b1, nd, lst, short_sector_length, 5'h0, c});
    cnt = '{default: 0};
    xs = 0;
    apb(1, fdc_param_pkg::OFF_CMD, {16'h0, 8'h2A, mt, dd, 6'h02});
    // a second command while busy is refused and leaves density and cylinder alone
    apb(1, fdc_param_pkg::OFF_CMD, 32'h5500);
    check("refused", e, 1);
    r = 32'h1;
    while (r[2:0] !== 3'h0 && n < 3000) begin
      apb(0, fdc_param_pkg::OFF_STATUS, 0);
      n++;
    end
    if (n >= 3000) num_errors++;
    if (n >= 3000) finish_test;
    check("head0 moves", cnt[0], lst * phys);
    check("head1 moves", cnt[1], mt ? lst * phys : 0);
    check("passed", cnt[2], hd * lst * bpb);
    check("dma moves", cnt[3], nd ? 0 : hd * lst * phys);
    check("irq moves", cnt[4], nd ? hd * lst * phys : 0);
    check("seeks", cnt[5], sk);
    if (sk) check("cylinder", seek_cyl, 8'h2A);
    check("density", double_density_sel, dd);
    check("settle", settle >= 2 * T && settle <= 4 * T + 4, 1);
    check("hold", hold >= 2 * T && hold <= 4 * T + 6, 1);
    check("unloaded", head_load, 0);
  endtask
  initial begin
    repeat (8) @(posedge clk_sys);
    rst <= 1'b0;
    t_regs;
    t_size;
    t_lock;
    t_run(1, 1, 0, 1, 3'h0, 8'h05, 8'h02, 4'h0);
    t_run(0, 0, 1, 0, 3'h1, 8'h00, 8'h01, 4'h3);
    finish_test;
  end
endmodule
bind floppy_cmd_param_decode floppy_cmd_param_decode_checker #(.TICK_CYCLES(TICK_CYCLES)) chk (
  .clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .dack_n(dack_n),
  .byte_strobe(byte_strobe), .seek_done(seek_done), .drq(drq), .byte_irq(byte_irq),
  .head_load(head_load), .seek_req(seek_req), .seek_cyl(seek_cyl), .head_sel(head_sel),
  .double_density_sel(double_density_sel), .fifo_bypass(fifo_bypass), .byte_pass(byte_pass));
`default_nettype wire

// ---- testbench/floppy_cmd_param_decode_checker.sv ----
// port-level assertions for the command parameter decoder
`timescale 1ns/10ps
`default_nettype none
module floppy_cmd_param_decode_checker #(
  parameter int TICK_CYCLES = fdc_param_pkg::TICK_CYC
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic dack_n,
  input wire logic byte_strobe,
  input wire logic seek_done,
  input wire logic drq,
  input wire logic byte_irq,
  input wire logic head_load,
  input wire logic seek_req,
  input wire logic [7:0] seek_cyl,
  input wire logic head_sel,
  input wire logic double_density_sel,
  input wire logic fifo_bypass,
  input wire logic byte_pass
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  a_mode_excl: assert property (!(drq && byte_irq))
    else $error("dma request and byte interrupt together");
  a_ack_done: assert property (drq && !dack_n |=> !drq)
    else $error("dma request kept after acknowledge");
  a_irq_clear: assert property (byte_irq && byte_strobe |=> !byte_irq)
    else $error("byte interrupt kept after host move");
  a_seek_hold: assert property (seek_req && !seek_done |=> seek_req)
    else $error("seek request dropped early");
  a_seek_end: assert property (seek_req && seek_done |=> !seek_req)
    else $error("seek request kept after done");
  a_seek_first: assert property (seek_req |-> !drq && !byte_irq)
    else $error("transfer during seek");
  a_xfer_loaded: assert property (drq || byte_irq |-> head_load)
    else $error("transfer with head unloaded");
  a_settle_gap: assert property ($rose(head_load) |-> !drq && !byte_irq)
    else $error("transfer at head load");
  a_unload_quiet: assert property ($fell(head_load) |-> !drq && !byte_irq)
    else $error("head unloaded during transfer");
  cover property (drq && !dack_n);
  cover property (byte_irq && byte_strobe);
  cover property (seek_req && seek_done);
  cover property ($fell(head_load));
endmodule
`default_nettype wire
